// [hw/sfx_exec_unit.sv]
// How it works
// - single stores write the chosen register to memory; register stays intact
// - store opcodes lead with digit 4; second digit picks the source register
// - second digit 0 writes an all-zero word, like storing the zero register
// - merge store writes accumulator address bits and on that same edge takes memory top nine bits
// - pair stores write first register at address, second at address OR 1
// - odd address in a pair store lets the second word overwrite the first
// - add, subtract and divide all update the condition flags from their result
// - add and subtract take a memory operand at the supplied effective address
// - add instructions sum memory into accumulator or an index register
// - add-to-memory sums accumulator and memory and writes memory back
// - subtract instructions take memory from accumulator, index two or three
// - divide uses register format; its count field sets result scaling
// - divide splits accumulator pair by index two; quotient in low count plus one bits
// - remainder high bits go low in second accumulator, rest atop the first
// - quotient sign lands at first accumulator bit position count, the top bit of the quotient field
// - a missing count means 23, which is also the largest count
// - divisor magnitude not above first accumulator magnitude traps to location 41
// - four flags overflow, zero, minus, carry change only on arithmetic
// - an instruction is a 24 bit word of opcode, modifier and operand
module sfx_exec_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Instruction issue
  input wire logic start,
  input wire logic [sfx_pkg::WORD_W-1:0] instr,
  input wire logic [sfx_pkg::ADDR_W-1:0] effAddr,
  output logic busy,
  output logic done,
  output logic trap,
  output logic [sfx_pkg::ADDR_W-1:0] trapAddr,
  // Register load from the rest of the processor
  input wire logic regLoad,
  input wire logic [2:0] regLoadSel,
  input wire logic [sfx_pkg::WORD_W-1:0] regLoadData,
  // Architectural state
  output sfx_pkg::sfx_regs_t regs,
  output sfx_pkg::sfx_cond_t cond,
  // Main storage
  output sfx_pkg::sfx_mem_req_t memReq,
  input wire logic memAck,
  input wire logic [sfx_pkg::WORD_W-1:0] memRdata
);
  import sfx_pkg::*;

  sfx_state_t state_reg;
  sfx_kind_t kind_reg;
  logic [WORD_W-1:0] instr_reg;
  logic [ADDR_W-1:0] ea_reg;
  logic [WORD_W-1:0] operand_reg;
  sfx_regs_t regs_reg;
  sfx_cond_t cond_reg;
  sfx_mem_req_t mem_reg;
  logic busy_reg;
  logic done_reg;
  logic trap_reg;
  logic [ADDR_W-1:0] trapAddr_reg;
  logic [DVD_W-1:0] dvd_reg;
  logic [DVD_W-1:0] quo_reg;
  logic [WORD_W:0] rem_reg;
  logic [WORD_W-1:0] dvs_reg;
  logic [5:0] step_reg;
  logic [4:0] cnt_reg;
  logic quoNeg_reg;
  logic remNeg_reg;

  // Register read by octal code; codes 0 and 1 read as zero
  function automatic logic [WORD_W-1:0] readReg(input sfx_regs_t r, input logic [2:0] sel);
    unique case (sel)
      SEL_ZERO, SEL_MERGE: readReg = RESET_WORD;
      SEL_PC: readReg = r.pc;
      SEL_ACC1: readReg = r.acc1;
      SEL_ACC2: readReg = r.acc2;
      SEL_IDX1: readReg = r.idx1;
      SEL_IDX2: readReg = r.idx2;
      SEL_IDX3: readReg = r.idx3;
    endcase
  endfunction : readReg

  // Register write by octal code; the zero register ignores writes
  function automatic sfx_regs_t setReg(input sfx_regs_t r, input logic [2:0] sel,
                                       input logic [WORD_W-1:0] v);
    setReg = r;
    unique case (sel)
      SEL_ZERO, SEL_MERGE: setReg = r;
      SEL_PC: setReg.pc = v;
      SEL_ACC1: setReg.acc1 = v;
      SEL_ACC2: setReg.acc2 = v;
      SEL_IDX1: setReg.idx1 = v;
      SEL_IDX2: setReg.idx2 = v;
      SEL_IDX3: setReg.idx3 = v;
    endcase
  endfunction : setReg

  // Opcode decode of a whole instruction word
  function automatic sfx_kind_t decodeKind(input logic [WORD_W-1:0] w);
    logic [5:0] op;
    op = w[OPCODE_MSB:OPCODE_LSB];
    if (op[5:3] == STORE_DIGIT) begin
      decodeKind = (op[2:0] == SEL_MERGE) ? K_MERGE : K_STORE;
    end else begin
      case (op)
        OP_STORE_PAIR_ACC_INDEX: decodeKind = K_PAIR_A;
        OP_STORE_PAIR_INDEX_HIGH: decodeKind = K_PAIR_X;
        OP_ADD_MEM_TO_FIRST_ACC, OP_ADD_MEM_TO_INDEX_ONE,
        OP_ADD_MEM_TO_INDEX_TWO, OP_ADD_MEM_TO_INDEX_THREE: decodeKind = K_ADD;
        OP_ADD_ACC_TO_MEMORY: decodeKind = K_ADM;
        OP_SUBTRACT_MEM_FROM_ACC, OP_SUBTRACT_MEM_FROM_INDEX_TWO,
        OP_SUBTRACT_MEM_FROM_INDEX_THREE: decodeKind = K_SUB;
        OP_DIVIDE: decodeKind = K_DIV;
        default: decodeKind = K_NONE;
      endcase
    end
  endfunction : decodeKind

  // Add or subtract with carry out in the top bit
  function automatic logic [WORD_W:0] addSub(input logic [WORD_W-1:0] a,
                                             input logic [WORD_W-1:0] b, input logic sub);
    logic [WORD_W-1:0] bb;
    bb = sub ? ~b : b;
    addSub = {1'b0, a} + {1'b0, bb} + {{WORD_W{1'b0}}, sub};
  endfunction : addSub

  // Flags from an add or subtract; carry means no borrow on subtract
  function automatic sfx_cond_t ccArith(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b,
                                        input logic sub, input logic [WORD_W:0] res);
    logic [WORD_W-1:0] bb;
    bb = sub ? ~b : b;
    ccArith.overflow = (a[WORD_W-1] == bb[WORD_W-1]) && (res[WORD_W-1] != a[WORD_W-1]);
    ccArith.zero = (res[WORD_W-1:0] == RESET_WORD);
    ccArith.minus = res[WORD_W-1];
    ccArith.carry = res[WORD_W];
  endfunction : ccArith

  // Magnitude of a two's complement word; the largest negative still fits
  function automatic logic [WORD_W-1:0] absWord(input logic [WORD_W-1:0] w);
    absWord = w[WORD_W-1] ? (~w + 24'h000001) : w;
  endfunction : absWord

  // Count of zero or beyond the limit falls back to 23
  function automatic logic [4:0] effCount(input logic [WORD_W-1:0] w);
    logic [4:0] c;
    c = w[COUNT_MSB:COUNT_LSB];
    effCount = (c == 5'h00 || c > DIV_COUNT_MAX) ? DIV_COUNT_DEFAULT : c;
  endfunction : effCount

  // Operation fields of the latched instruction
  logic [2:0] opSel;
  logic isSub;
  logic [WORD_W-1:0] arithA;
  logic [WORD_W:0] arithRes;
  logic divTrap;
  assign opSel = instr_reg[OPCODE_LSB+2:OPCODE_LSB];
  assign isSub = (kind_reg == K_SUB);
  assign arithA = (kind_reg == K_ADM) ? regs_reg.acc1 : readReg(regs_reg, opSel);
  assign arithRes = addSub(arithA, memRdata, isSub);
  assign divTrap = absWord(regs_reg.idx2) <= absWord(regs_reg.acc1);

  // Dividend: accumulator pair without the excluded last bit, magnitude, scaled right
  logic [DVD_W-1:0] dvdRaw;
  logic [DVD_W-1:0] dvdMag;
  logic [4:0] startCnt;
  assign dvdRaw = {regs_reg.acc1, regs_reg.acc2[WORD_W-1:1]};
  assign dvdMag = dvdRaw[DVD_W-1] ? (~dvdRaw + 47'h000000000001) : dvdRaw;
  assign startCnt = effCount(instr_reg);

  // One restoring step per cycle keeps the divider small; 47 step cycles, 50 busy cycles per divide
  logic [WORD_W:0] remShift;
  logic remFits;
  assign remShift = {rem_reg[WORD_W-1:0], dvd_reg[DVD_W-1]};
  assign remFits = remShift >= {1'b0, dvs_reg};

  // Result placement for the chosen count
  logic [WORD_W-1:0] quoSigned;
  logic [WORD_W-2:0] remSigned;
  logic [WORD_W-1:0] quoMask;
  logic [WORD_W-1:0] divRa;
  logic [WORD_W-1:0] divRb;
  assign quoSigned = quoNeg_reg ? (~quo_reg[WORD_W-1:0] + 24'h000001) : quo_reg[WORD_W-1:0];
  assign remSigned = (remNeg_reg ? (~rem_reg[WORD_W-2:0] + 23'h000001) : rem_reg[WORD_W-2:0])
                     << (DIV_COUNT_MAX - cnt_reg); // Cleared low dividend bits fill below
  assign quoMask = (24'h000001 << (cnt_reg + 5'h01)) - 24'h000001;
  assign divRa = ({remSigned, 1'b0} << cnt_reg) | (quoSigned & quoMask);
  assign divRb = {1'b0, remSigned} >> (DIV_COUNT_MAX - cnt_reg);

  // Sequencer and main storage requests; one instruction at a time
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      kind_reg <= K_NONE;
      instr_reg <= RESET_WORD;
      ea_reg <= '0;
      operand_reg <= RESET_WORD;
      mem_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (start) begin
            instr_reg <= instr;
            ea_reg <= effAddr;
            kind_reg <= decodeKind(instr);
            busy_reg <= 1'b1;
            unique case (decodeKind(instr))
              K_STORE: begin
                mem_reg <= '{1'b1, 1'b1, effAddr,
                             readReg(regs_reg, instr[OPCODE_LSB+2:OPCODE_LSB])};
                state_reg <= S_WRITE1;
              end
              K_PAIR_A: begin
                mem_reg <= '{1'b1, 1'b1, effAddr, regs_reg.acc1};
                state_reg <= S_WRITE1;
              end
              K_PAIR_X: begin
                mem_reg <= '{1'b1, 1'b1, effAddr, regs_reg.idx2};
                state_reg <= S_WRITE1;
              end
              K_MERGE, K_ADD, K_ADM, K_SUB: begin
                mem_reg <= '{1'b1, 1'b0, effAddr, RESET_WORD};
                state_reg <= S_READ;
              end
              K_DIV: state_reg <= S_DIV_START;
              K_NONE: state_reg <= S_FINISH;
            endcase
          end
        end
        S_WRITE1: begin
          if (memAck) begin
            if (kind_reg == K_PAIR_A || kind_reg == K_PAIR_X) begin
              // Odd address ORs to itself, so the second word lands on the first
              mem_reg.addr <= ea_reg | 15'h0001;
              mem_reg.wdata <= (kind_reg == K_PAIR_A) ? regs_reg.idx1 : regs_reg.idx3;
              state_reg <= S_WRITE2;
            end else begin
              mem_reg.req <= 1'b0;
              state_reg <= S_FINISH;
            end
          end
        end
        S_READ: begin
          if (memAck) begin
            operand_reg <= memRdata;
            if (kind_reg == K_MERGE) begin
              mem_reg.we <= 1'b1;
              mem_reg.wdata <= {memRdata[WORD_W-1:ADDR_FIELD_MSB+1],
                                regs_reg.acc1[ADDR_FIELD_MSB:0]};
              state_reg <= S_WRITEBACK;
            end else if (kind_reg == K_ADM) begin
              mem_reg.we <= 1'b1;
              mem_reg.wdata <= arithRes[WORD_W-1:0];
              state_reg <= S_WRITEBACK;
            end else begin
              mem_reg.req <= 1'b0;
              state_reg <= S_FINISH;
            end
          end
        end
        S_WRITE2, S_WRITEBACK: begin
          if (memAck) begin
            mem_reg.req <= 1'b0;
            state_reg <= S_FINISH;
          end
        end
        S_DIV_START: state_reg <= divTrap ? S_FINISH : S_DIV;
        S_DIV: if (step_reg == DIV_STEPS - 6'h01) state_reg <= S_DIV_PLACE;
        S_DIV_PLACE: state_reg <= S_FINISH;
        S_FINISH: begin
          busy_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Working registers; outside loads are taken only while idle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regs_reg <= '0;
    end else if (state_reg == S_IDLE) begin
      if (regLoad) begin
        regs_reg <= setReg(regs_reg, regLoadSel, regLoadData);
      end
    end else if (state_reg == S_READ && memAck && (kind_reg == K_ADD || isSub)) begin
      regs_reg <= setReg(regs_reg, opSel, arithRes[WORD_W-1:0]);
    end else if (state_reg == S_WRITEBACK && memAck && kind_reg == K_MERGE) begin
      // Memory is written on this same ack edge on which the accumulator takes the top bits
      regs_reg.acc1[WORD_W-1:ADDR_FIELD_MSB+1] <=
        operand_reg[WORD_W-1:ADDR_FIELD_MSB+1];
    end else if (state_reg == S_DIV_PLACE) begin
      regs_reg.acc1 <= divRa;
      regs_reg.acc2 <= divRb;
    end
  end

  // Condition flags; stores and loads leave them alone
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cond_reg <= '0;
    end else if (state_reg == S_READ && memAck && kind_reg inside {K_ADD, K_ADM, K_SUB}) begin
      cond_reg <= ccArith(arithA, memRdata, isSub, arithRes);
    end else if (state_reg == S_DIV_START && divTrap) begin
      cond_reg.overflow <= 1'b1;
    end else if (state_reg == S_DIV_PLACE) begin
      cond_reg.overflow <= 1'b0;
      cond_reg.carry <= 1'b0;
      cond_reg.zero <= (quoSigned & quoMask) == RESET_WORD;
      cond_reg.minus <= quoSigned[WORD_W-1];
    end
  end

  // Divider datapath; works on magnitudes and fixes signs at the end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dvd_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
      dvs_reg <= RESET_WORD;
      step_reg <= 6'h00;
      cnt_reg <= DIV_COUNT_DEFAULT;
      quoNeg_reg <= 1'b0;
      remNeg_reg <= 1'b0;
    end else if (state_reg == S_DIV_START) begin
      // Bits shifted out here are lost; software must have cleared them
      dvd_reg <= dvdMag >> (DIV_COUNT_MAX - startCnt);
      cnt_reg <= startCnt;
      dvs_reg <= absWord(regs_reg.idx2);
      quo_reg <= '0;
      rem_reg <= '0;
      step_reg <= 6'h00;
      quoNeg_reg <= regs_reg.acc1[WORD_W-1] ^ regs_reg.idx2[WORD_W-1];
      remNeg_reg <= regs_reg.acc1[WORD_W-1];
    end else if (state_reg == S_DIV) begin
      rem_reg <= remFits ? (remShift - {1'b0, dvs_reg}) : remShift;
      quo_reg <= {quo_reg[DVD_W-2:0], remFits};
      dvd_reg <= {dvd_reg[DVD_W-2:0], 1'b0};
      step_reg <= step_reg + 6'h01;
    end
  end

  // Status pulses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
      trap_reg <= 1'b0;
      trapAddr_reg <= '0;
    end else begin
      done_reg <= (state_reg == S_FINISH);
      trap_reg <= (state_reg == S_DIV_START) && divTrap;
      trapAddr_reg <= TRAP_VECTOR;
    end
  end

  // Outputs straight from flip-flops
  assign busy = busy_reg;
  assign done = done_reg;
  assign trap = trap_reg;
  assign trapAddr = trapAddr_reg;
  assign regs = regs_reg;
  assign cond = cond_reg;
  assign memReq = mem_reg;
endmodule : sfx_exec_unit

// [hw/sfx_pkg.sv]
package sfx_pkg;
  // Word and address widths
  localparam int WORD_W = 24;
  localparam int ADDR_W = 15;
  localparam int DVD_W = 47;
  // Instruction field positions (bit 23 is the word's first bit)
  localparam int OPCODE_MSB = 23;
  localparam int OPCODE_LSB = 18;
  localparam int MOD_MSB = 17;
  localparam int MOD_LSB = 15;
  localparam int ADDR_FIELD_MSB = 14;
  localparam int COUNT_MSB = 4;
  localparam int COUNT_LSB = 0;
  // Store group: leading octal digit and source codes
  localparam logic [2:0] STORE_DIGIT = 3'h4;
  localparam logic [2:0] SEL_ZERO = 3'h0;
  localparam logic [2:0] SEL_MERGE = 3'h1;
  localparam logic [2:0] SEL_PC = 3'h2;
  localparam logic [2:0] SEL_ACC1 = 3'h3;
  localparam logic [2:0] SEL_ACC2 = 3'h4;
  localparam logic [2:0] SEL_IDX1 = 3'h5;
  localparam logic [2:0] SEL_IDX2 = 3'h6;
  localparam logic [2:0] SEL_IDX3 = 3'h7;
  // Other opcodes (octal 61, 62, 63, 65, 66, 67, 64, 73, 76, 77, 13)
  localparam logic [5:0] OP_STORE_PAIR_ACC_INDEX = 6'h31;
  localparam logic [5:0] OP_STORE_PAIR_INDEX_HIGH = 6'h32;
  localparam logic [5:0] OP_ADD_MEM_TO_FIRST_ACC = 6'h33;
  localparam logic [5:0] OP_ADD_MEM_TO_INDEX_ONE = 6'h35;
  localparam logic [5:0] OP_ADD_MEM_TO_INDEX_TWO = 6'h36;
  localparam logic [5:0] OP_ADD_MEM_TO_INDEX_THREE = 6'h37;
  localparam logic [5:0] OP_ADD_ACC_TO_MEMORY = 6'h34;
  localparam logic [5:0] OP_SUBTRACT_MEM_FROM_ACC = 6'h3B;
  localparam logic [5:0] OP_SUBTRACT_MEM_FROM_INDEX_TWO = 6'h3E;
  localparam logic [5:0] OP_SUBTRACT_MEM_FROM_INDEX_THREE = 6'h3F;
  localparam logic [5:0] OP_DIVIDE = 6'h0B;
  // Divide count and trap
  localparam logic [4:0] DIV_COUNT_DEFAULT = 5'h17;
  localparam logic [4:0] DIV_COUNT_MAX = 5'h17;
  localparam logic [5:0] DIV_STEPS = 6'h2F;
  localparam logic [ADDR_W-1:0] TRAP_VECTOR = 15'h0041;
  // Reset values
  localparam logic [WORD_W-1:0] RESET_WORD = 24'h000000;

  typedef enum logic [3:0] {
    K_NONE, K_STORE, K_MERGE, K_PAIR_A, K_PAIR_X, K_ADD, K_ADM, K_SUB, K_DIV
  } sfx_kind_t;

  typedef enum logic [3:0] {
    S_IDLE, S_WRITE1, S_WRITE2, S_READ, S_WRITEBACK, S_DIV_START, S_DIV,
    S_DIV_PLACE, S_FINISH
  } sfx_state_t;

  typedef struct packed {
    logic overflow;
    logic zero;
    logic minus;
    logic carry;
  } sfx_cond_t;

  typedef struct packed {
    logic [WORD_W-1:0] pc;
    logic [WORD_W-1:0] acc1;
    logic [WORD_W-1:0] acc2;
    logic [WORD_W-1:0] idx1;
    logic [WORD_W-1:0] idx2;
    logic [WORD_W-1:0] idx3;
  } sfx_regs_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } sfx_mem_req_t;
endpackage : sfx_pkg

// [sim/sfx_exec_checker.sv]
module sfx_exec_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Issue and completion
  input wire logic start,
  input wire logic [23:0] instr,
  input wire logic [14:0] effAddr,
  input wire logic busy,
  input wire logic done,
  input wire logic trap,
  input wire logic [14:0] trapAddr,
  // Register load
  input wire logic regLoad,
  input wire logic [2:0] regLoadSel,
  input wire logic [23:0] regLoadData,
  // State and main storage
  input sfx_pkg::sfx_regs_t regs,
  input sfx_pkg::sfx_cond_t cond,
  input sfx_pkg::sfx_mem_req_t memReq,
  input wire logic memAck,
  input wire logic [23:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import sfx_pkg::*;
  logic [1:0] kindReg;
  logic wroteReg;
  logic [14:0] eaReg;
  logic [23:0] loReg;
  logic [23:0] hiReg;
  logic [5:0] op;
  assign op = instr[23:18];

  function automatic logic [23:0] pick(input logic [2:0] c);
    pick = (c < 3'h2) ? 24'h000000 : regs[(7 - c) * 24 +: 24];
  endfunction : pick

  // Expected words are frozen at issue, since the sources may change later
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      kindReg <= 2'h0;
      eaReg <= 15'h0000;
      loReg <= 24'h000000;
      hiReg <= 24'h000000;
    end else if (start && !busy) begin
      eaReg <= effAddr;
      hiReg <= pick(op[0] ? SEL_IDX1 : SEL_IDX3);
      loReg <= (op == OP_STORE_PAIR_INDEX_HIGH) ? pick(SEL_IDX2) :
               (op[5:3] == STORE_DIGIT) ? pick(op[2:0]) : pick(SEL_ACC1);
      if (op[5:3] == STORE_DIGIT) begin
        kindReg <= (op[2:0] == SEL_MERGE) ? 2'h3 : 2'h1;
      end else if (op == OP_STORE_PAIR_ACC_INDEX || op == OP_STORE_PAIR_INDEX_HIGH) begin
        kindReg <= 2'h2;
      end else begin
        kindReg <= (op == OP_ADD_ACC_TO_MEMORY) ? 2'h3 : 2'h0;
      end
    end
  end

  // First completed access of an instruction
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wroteReg <= 1'b0;
    end else if (start && !busy) begin
      wroteReg <= 1'b0;
    end else if (memReq.req && memAck) begin
      wroteReg <= 1'b1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  issue_busy_a: assert property (start && !busy |=> busy)
    else $error("busy missing after issue");
  finish_done_a: assert property ($fell(busy) |-> ##[0:1] done)
    else $error("done missing after finish");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  trap_vector_a: assert property (trap |-> trapAddr == TRAP_VECTOR)
    else $error("trap address wrong");
  trap_keep_a: assert property (trap |-> $stable(regs) ##1 done)
    else $error("trap changed registers");
  req_hold_a: assert property (memReq.req && !memAck |=> memReq.req && $stable(memReq))
    else $error("request moved before ack");
  first_write_a: assert property (kindReg inside {2'h1, 2'h2} && !wroteReg && memReq.req
    |-> memReq.we && memReq.addr == eaReg && memReq.wdata == loReg && $stable(regs))
    else $error("first store write wrong");
  pair_second_a: assert property (kindReg == 2'h2 && !wroteReg && memReq.req && memAck
    |=> memReq.req && memReq.we && memReq.addr == (eaReg | 15'h0001) && memReq.wdata == hiReg)
    else $error("second pair write wrong");
  rmw_order_a: assert property (kindReg == 2'h3 && memReq.req && !memReq.we && memAck
    |=> memReq.req && memReq.we && $stable(memReq.addr))
    else $error("write back missing after read");
  idle_flags_a: assert property (!busy |=> $stable(cond))
    else $error("flags changed while idle");
endmodule : sfx_exec_checker

bind sfx_exec_unit sfx_exec_checker checkInst (
  .clock(clock), .rstn(rstn), .start(start), .instr(instr), .effAddr(effAddr),
  .busy(busy), .done(done), .trap(trap), .trapAddr(trapAddr), .regLoad(regLoad),
  .regLoadSel(regLoadSel), .regLoadData(regLoadData), .regs(regs), .cond(cond),
  .memReq(memReq), .memAck(memAck), .memRdata(memRdata)
);

// [sim/sfx_exec_unit_tb_top.sv]
module sfx_exec_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sfx_pkg::*;
  logic clock = 1'b0;
  logic rstn, start, regLoad, busy, done, trap, memAck, sawTrap;
  logic [23:0] instr, regLoadData, memRdata;
  logic [14:0] effAddr, trapAddr;
  logic [2:0] regLoadSel;
  logic [1:0] lag;
  sfx_regs_t regs;
  sfx_cond_t cond;
  sfx_mem_req_t memReq;
  logic [23:0] sh [0:7];
  int fails = 0;
  int num_checks = 0;
  localparam logic [5:0] OPS [7] = '{OP_ADD_MEM_TO_FIRST_ACC, OP_ADD_MEM_TO_INDEX_ONE,
    OP_ADD_MEM_TO_INDEX_TWO, OP_ADD_MEM_TO_INDEX_THREE, OP_SUBTRACT_MEM_FROM_ACC,
    OP_SUBTRACT_MEM_FROM_INDEX_TWO, OP_SUBTRACT_MEM_FROM_INDEX_THREE};
  localparam logic [2:0] TGT [7] = '{3'h3, 3'h5, 3'h6, 3'h7, 3'h3, 3'h6, 3'h7};
  // Dividend high, low, divisor, count, quotient word, remainder word
  localparam logic [23:0] DVT [4][6] = '{
    '{24'h000002, 24'h000000, 24'h000009, 24'h000017, 24'h1C71C7, 24'h000001},
    '{24'h000002, 24'h000000, 24'h000009, 24'h000010, 24'h0038E3, 24'h000005},
    '{24'h000002, 24'h000000, 24'h000009, 24'h000000, 24'h1C71C7, 24'h000001},
    '{24'h000000, 24'h00000E, 24'h000003, 24'h000017, 24'h000002, 24'h000001}};

  always #50 clock = ~clock;

  sfx_exec_unit uut (.clock(clock), .rstn(rstn), .start(start), .instr(instr),
    .effAddr(effAddr), .busy(busy), .done(done), .trap(trap), .trapAddr(trapAddr),
    .regLoad(regLoad), .regLoadSel(regLoadSel), .regLoadData(regLoadData),
    .regs(regs), .cond(cond), .memReq(memReq), .memAck(memAck), .memRdata(memRdata));
  sfx_mem_model mem (.clock(clock), .rstn(rstn), .lag(lag), .memReq(memReq),
    .memAck(memAck), .memRdata(memRdata));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [23:0] rd(input logic [2:0] c);
    rd = (c < 3'h2) ? 24'h000000 : regs[(7 - c) * 24 +: 24];
  endfunction : rd

  // Flags then sum; subtract is a plus inverted b plus one
  function automatic logic [27:0] alu(input logic [23:0] a, input logic [23:0] b, input logic s);
    logic [23:0] bb;
    logic [24:0] r;
    bb = s ? ~b : b;
    r = {1'b0, a} + {1'b0, bb} + 25'(s);
    alu = {a[23] == bb[23] && r[23] != a[23], r[23:0] == 24'h000000, r[23], r[24], r[23:0]};
  endfunction : alu

  // Register load is only taken while idle, so it runs between instructions
  task automatic setr(input logic [2:0] c, input logic [23:0] v);
    @(posedge clock);
    regLoad <= 1'b1;
    regLoadSel <= c;
    regLoadData <= v;
    @(posedge clock);
    regLoad <= 1'b0;
    @(negedge clock);
    sh[c] = v;
  endtask : setr

  // Issue one instruction with a fresh memory pace, then wait for done
  task automatic run(input logic [23:0] ins, input logic [14:0] ea);
    int n;
    n = 0;
    sawTrap = 1'b0;
    @(posedge clock);
    start <= 1'b1;
    instr <= ins;
    effAddr <= ea;
    lag <= 2'($urandom);
    @(posedge clock);
    start <= 1'b0;
    do begin
      @(negedge clock);
      sawTrap |= (trap === 1'b1);
      n++;
    end while (done !== 1'b1 && n < 300);
    if (n >= 300) chk("done", 24'h000001, 24'h000000);
  endtask : run

  initial begin
    logic [23:0] a, b, w;
    logic [14:0] ea;
    logic [27:0] e;
    int k;
    {start, regLoad, regLoadSel, lag, rstn} = '0;
    {instr, effAddr, regLoadData} = '0;
    sh[0] = 24'h000000;
    k = $urandom(91919);
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(negedge clock);
    chk("trap vector", 24'(TRAP_VECTOR), 24'(trapAddr));
    for (int c = 2; c < 8; c++) setr(3'(c), 24'($urandom));
    // Single and zero stores; the word is opcode, modifier, operand
    for (int c = 0; c < 8; c++) begin
      if (c == 1) continue;
      ea = 15'($urandom);
      mem.store[ea] = 24'hA5A5A5;
      run({STORE_DIGIT, 3'(c), 3'h0, ea}, ea);
      chk("store word", sh[c], mem.store[ea]);
      chk("source kept", sh[c], rd(3'(c)));
    end
    // Address merge
    ea = 15'($urandom);
    w = 24'($urandom);
    a = sh[3];
    mem.store[ea] = w;
    run({STORE_DIGIT, SEL_MERGE, 3'h0, ea}, ea);
    sh[3] = {w[23:15], a[14:0]};
    chk("merge memory", sh[3], mem.store[ea]);
    chk("merge acc", sh[3], rd(SEL_ACC1));
    // Pair stores at even and odd addresses
    for (int p = 0; p < 4; p++) begin
      ea = {14'($urandom), 1'(p)};
      run({p[1] ? OP_STORE_PAIR_INDEX_HIGH : OP_STORE_PAIR_ACC_INDEX, 3'h0, ea}, ea);
      a = p[1] ? sh[6] : sh[3];
      b = p[1] ? sh[7] : sh[5];
      chk("pair first", p[0] ? b : a, mem.store[ea]);
      chk("pair second", b, mem.store[ea | 15'h0001]);
    end
    // Add and subtract; the first pass is the carry-to-zero corner
    for (int i = 0; i < 21; i++) begin
      k = i % 7;
      a = (i == 0) ? 24'hFFFFFE : 24'($urandom);
      b = (i == 0) ? 24'h000002 : 24'($urandom);
      setr(TGT[k], a);
      ea = 15'($urandom);
      mem.store[ea] = b;
      run({OPS[k], 3'h0, ea}, ea);
      e = alu(a, b, k > 3);
      chk("arith result", e[23:0], rd(TGT[k]));
      chk("arith flags", 24'(e[27:24]), 24'(cond));
      sh[TGT[k]] = e[23:0];
    end
    // Add accumulator into memory
    b = 24'($urandom);
    mem.store[ea] = b;
    run({OP_ADD_ACC_TO_MEMORY, 3'h0, ea}, ea);
    e = alu(sh[3], b, 1'b0);
    chk("memory sum", e[23:0], mem.store[ea]);
    chk("memory flags", 24'(e[27:24]), 24'(cond));
    // Divide with prepared dividends, including the omitted count
    for (int t = 0; t < 4; t++) begin
      setr(SEL_ACC1, DVT[t][0]);
      setr(SEL_ACC2, DVT[t][1]);
      setr(SEL_IDX2, DVT[t][2]);
      run({OP_DIVIDE, 3'h7, 10'h000, DVT[t][3][4:0]}, 15'h0000);
      chk("quotient word", DVT[t][4], rd(SEL_ACC1));
      chk("remainder word", DVT[t][5], rd(SEL_ACC2));
      chk("divide flags", 24'h000000, 24'(cond));
    end
    // Divisor not above first accumulator traps and keeps registers
    setr(SEL_ACC1, 24'h000005);
    setr(SEL_IDX2, 24'h000001);
    w = 24'(cond);
    run({OP_DIVIDE, 3'h7, 10'h000, 5'h17}, 15'h0000);
    chk("trap pulse", 24'h000001, 24'(sawTrap));
    chk("trap acc", 24'h000005, rd(SEL_ACC1));
    chk("trap flags", w | 24'h000008, 24'(cond));
    run(24'h000000, ea); // Unknown opcode completes as a no-op
    chk("no-op flags", w | 24'h000008, 24'(cond));
    complete_run();
  end

  // About 40 instructions of under 60 cycles each fit well inside 50000 cycles
  initial begin
    #5000000;
    fails++;
    complete_run();
  end
endmodule : sfx_exec_unit_tb_top

// [sim/sfx_mem_model.sv]
module sfx_mem_model (
  // Clock, reset and pacing
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] lag,
  // Memory port
  input sfx_pkg::sfx_mem_req_t memReq,
  output logic memAck,
  output logic [23:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import sfx_pkg::*;
  logic [WORD_W-1:0] store [0:32767];
  logic [1:0] waitReg;
  logic [WORD_W-1:0] lastReg;
  // Ack after lag cycles of a held request; zero lag acks at once
  assign memAck = memReq.req && waitReg == lag;
  // Outside an ack the lines show the inverse of the last word, never a stale copy
  assign memRdata = memAck ? store[memReq.addr] : ~lastReg;
  // Writes land on the ack edge
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waitReg <= 2'h0;
      lastReg <= 24'h000000;
    end else if (memAck) begin
      waitReg <= 2'h0;
      lastReg <= memRdata;
      if (memReq.we) begin
        store[memReq.addr] <= memReq.wdata;
      end
    end else if (memReq.req) begin
      waitReg <= waitReg + 2'h1;
    end
  end
endmodule : sfx_mem_model
